// ---- hdl/slfc_pkg.sv ----
// Purpose: Shared constants and state types for the serial link flow control block.
// Assumes: One clock domain; all widths are fixed by the link protocol.
// Notes:   Shared widths, limits, stype1 codes and reset defaults live here; other files still write some widths as literals.
package slfc_pkg;
	localparam int unsigned ACK_W     = 5;
	localparam int unsigned S0_W      = 13;
	localparam int unsigned S1_W      = 6;
	localparam int unsigned FB_W      = 10;
	localparam int unsigned TS_W      = 16;
	localparam int unsigned BLK_BYTES = 64;
	localparam int unsigned KBYTE     = 1024;
	// Field position of the stype1 code inside a 6-bit symbol.
	localparam int unsigned ST1_LSB   = 3;
	localparam logic [2:0]  ST1_STOMP = 3'h1;
	localparam logic [2:0]  ST1_RFR   = 3'h3;
	localparam logic [2:0]  ST1_LREQ  = 3'h4;
	localparam logic [5:0]  MAX_OUT   = 6'h1F;
	localparam logic [2:0]  MAX_BLK   = 3'h5;
	localparam logic [2:0]  RSTDEV_N  = 3'h4;
	localparam logic [9:0]  THR2_DEF  = 10'h00A;
	localparam logic [9:0]  THR1_DEF  = 10'h00F;
	localparam logic [9:0]  THR0_DEF  = 10'h014;
	localparam logic [15:0] TO_DEF    = 16'h03E8;
	typedef enum logic [1:0] {in_ok = 2'b01, in_err = 2'b10} slfc_in_e;
	typedef enum logic [1:0] {out_ok = 2'b01, out_err = 2'b10} slfc_out_e;
endpackage

// ---- hdl/slfc_fifo_if.sv ----
// Purpose: Carrier between the flow control core and its receive data buffer.
// Assumes: Both ends on the same clock.
// Notes:   The clear line drops every stored word.
`timescale 1ns/1ps
interface slfc_fifo_if #(parameter int unsigned W = 32);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	logic         clear;
	modport src  (output in_valid, in_data, out_ready, clear, input in_ready, out_valid, out_data);
	modport fifo (input in_valid, in_data, out_ready, clear, output in_ready, out_valid, out_data);
endinterface

// ---- hdl/slfc_fifo.sv ----
// Purpose: Receive data buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Output word and both handshake flags are registered.
`timescale 1ns/1ps
module slfc_fifo #(
	parameter int unsigned W     = 32,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	slfc_fifo_if.fifo f
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	logic          rdy_r;
	logic          ov_r;
	logic [W-1:0]  od_r;
	logic          push;
	logic          pop;
	logic          ov_nxt;

	assign push = f.in_valid && rdy_r;
	assign pop = (cnt_r != '0) && (!ov_r || f.out_ready);
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign ov_nxt = pop || (ov_r && !f.out_ready);
	assign f.in_ready = rdy_r;
	assign f.out_valid = ov_r;
	assign f.out_data = od_r;

	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wp_r] <= f.in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
			ov_r <= 1'b0;
			od_r <= '0;
		end else if (ce) begin
			if (f.clear) begin
				wp_r <= '0;
				rp_r <= '0;
				cnt_r <= '0;
				rdy_r <= 1'b1;
				ov_r <= 1'b0;
			end else begin
				if (push) begin
					wp_r <= wp_r + 1'b1;
				end
				if (pop) begin
					rp_r <= rp_r + 1'b1;
					od_r <= mem[rp_r];
				end
				ov_r <= ov_nxt;
				cnt_r <= cnt_nxt;
				// The parked output word counts too, so DEPTH words in all fill the buffer.
				rdy_r <= (cnt_nxt + (AW+1)'(ov_nxt)) != (AW+1)'(DEPTH);
			end
		end
	end

	property p_full_stalls;
		@(posedge clock) disable iff (rst) cnt_r == (AW+1)'(DEPTH) |-> !rdy_r;
	endproperty
	a_full_stalls: assert property (p_full_stalls) else $error("buffer full but ready");
endmodule

// ---- hdl/slfc_top.sv ----
// Purpose: Link flow control: ackID windows, error recovery, receive accept or retry.
// Assumes: All inputs come from logic on the same clock; symbols arrive decoded.
// Notes:   Receive data is decoupled from the user by a registered buffer.
// Function
// - Stype0 symbols enter on a 13-bit port, stype1 symbols on a 6-bit port.
// - Stomp, restart-from-retry and link-request stype1 symbols are flagged as terminators.
// - Receive logic and transmit logic each stay within a single clock domain.
// - Receive side reports which packets are kept and which are dropped.
// - Each ackID is five bits, starts at zero and wraps after 31.
// - Only the next expected ackID is accepted; others are refused.
// - Congestion sends a retry naming the ackID; sender resends from it.
// - CRC errors send not-accepted; link-request/response exchange; resend from bad ackID.
// - Two interdependent state machines run input and output recovery.
// - Transmit side names next ackID and which sent packets are acknowledged.
// - Each outgoing packet is timed; expiry acts as unexpected acknowledge.
// - Protocol violations or corrupt symbols or packets start error recovery.
// - Sent packets are held until their packet-accepted symbol arrives.
// - A retransmitted packet restarts its time-out from the beginning.
// - Receive buffer uses 64-byte blocks, at most five per packet.
// - Priority 3 packets retry only when the buffer is full.
// - Priorities 2, 1, 0 retry when free blocks fall below their threshold.
// - Threshold defaults are 10, 15 and 20.
// - Receive data crosses to the user side through a decoupling buffer.
// - Receive buffer size is a build choice of 4, 8, 16 or 32 KB.
// - Fatal link conditions flush the receive buffer.
`timescale 1ns/1ps
module slfc_top #(
	parameter int unsigned BUF_KB = 32,
	parameter int unsigned FIFO_W = 32,
	parameter int unsigned FIFO_D = 32,
	parameter logic [15:0] TO_CYC = slfc_pkg::TO_DEF
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              s0_in_valid,
	input  wire logic [12:0]       s0_in_data,
	input  wire logic              s1_in_valid,
	input  wire logic [5:0]        s1_in_data,
	output logic                   s0_out_valid_r,
	output logic [12:0]            s0_out_data_r,
	output logic                   s1_out_valid_r,
	output logic [5:0]             s1_out_data_r,
	output logic                   pkt_term_r,
	input  wire logic              tx_pkt_sent,
	output logic                   tx_send_ok_r,
	output logic [4:0]             tx_ackid_r,
	output logic                   tx_free_r,
	output logic [4:0]             tx_free_ackid_r,
	output logic                   tx_rewind_r,
	input  wire logic              rs_pa,
	input  wire logic              rs_retry,
	input  wire logic              rs_pna,
	input  wire logic              rs_presp,
	input  wire logic              rs_presp_err,
	input  wire logic [4:0]        rs_ackid,
	input  wire logic              rs_lreq,
	input  wire logic              rs_lreq_rstdev,
	input  wire logic              rs_sym_err,
	input  wire logic              rp_start,
	input  wire logic [4:0]        rp_ackid,
	input  wire logic [1:0]        rp_prio,
	input  wire logic              rp_end,
	input  wire logic              rp_crc_err,
	output logic                   ss_pa_r,
	output logic                   ss_retry_r,
	output logic                   ss_pna_r,
	output logic                   ss_lreq_r,
	output logic                   ss_lresp_r,
	output logic [4:0]             ss_ackid_r,
	output logic                   rx_keep_r,
	output logic                   rx_drop_r,
	output logic                   flush_r,
	input  wire logic              blk_alloc,
	input  wire logic              blk_free,
	output logic [9:0]             free_blks_r,
	input  wire logic              cfg_thr_we,
	input  wire logic [9:0]        cfg_thr2,
	input  wire logic [9:0]        cfg_thr1,
	input  wire logic [9:0]        cfg_thr0,
	input  wire logic              rx_data_valid,
	input  wire logic [FIFO_W-1:0] rx_data,
	output logic                   rx_data_ready,
	output logic                   usr_valid,
	output logic [FIFO_W-1:0]      usr_data,
	input  wire logic              usr_ready
);
	localparam logic [9:0] BLKS = 10'(BUF_KB * slfc_pkg::KBYTE / slfc_pkg::BLK_BYTES);

	slfc_pkg::slfc_in_e  in_st_r;
	slfc_pkg::slfc_out_e out_st_r;
	logic [4:0]  rx_exp_r;
	logic        pkt_act_r;
	logic [2:0]  pkt_blk_r;
	logic [9:0]  thr2_r;
	logic [9:0]  thr1_r;
	logic [9:0]  thr0_r;
	logic [9:0]  thr_sel;
	logic [15:0] now_r;
	logic [15:0] in_ts_r;
	logic [15:0] out_ts_r;
	logic [15:0] stamp [32];
	logic [5:0]  tx_cnt_r;
	logic [5:0]  tx_cnt_nxt;
	logic [4:0]  tx_una_r;
	logic [2:0]  rstdev_r;
	logic        congest;
	logic        err_in;
	logic        pa_ok;
	logic        retry_ok;
	logic        unexp;
	logic        in_win;
	logic        presp_bad;
	logic        in_to;
	logic        out_to;
	logic        pkt_to;
	logic        rstdev_hit;
	logic        flush_c;

	//------------------------------------------------------------
	// Decisions
	//------------------------------------------------------------
	assign thr_sel = (rp_prio == 2'h2) ? thr2_r : (rp_prio == 2'h1) ? thr1_r : thr0_r;
	assign congest = (rp_prio == 2'h3) ? (free_blks_r == '0) : (free_blks_r < thr_sel);
	assign err_in = rs_sym_err || (rp_end && pkt_act_r && rp_crc_err)
		|| (rp_start && rp_ackid != rx_exp_r)
		|| (blk_alloc && pkt_act_r && pkt_blk_r == slfc_pkg::MAX_BLK);
	assign pa_ok = rs_pa && tx_cnt_r != '0 && rs_ackid == tx_una_r;
	assign retry_ok = rs_retry && tx_cnt_r != '0 && rs_ackid == tx_una_r;
	assign pkt_to = tx_cnt_r != '0 && 16'(now_r - stamp[tx_una_r]) >= TO_CYC;
	assign unexp = (rs_pa && !pa_ok) || (rs_retry && !retry_ok) || rs_pna || pkt_to;
	assign in_win = {1'b0, 5'(rs_ackid - tx_una_r)} <= tx_cnt_r;
	assign presp_bad = rs_presp && (rs_presp_err || !in_win);
	assign in_to = in_st_r == slfc_pkg::in_err && 16'(now_r - in_ts_r) >= TO_CYC;
	assign out_to = out_st_r == slfc_pkg::out_err && 16'(now_r - out_ts_r) >= TO_CYC;
	assign rstdev_hit = rs_lreq && rs_lreq_rstdev && rstdev_r == slfc_pkg::RSTDEV_N - 3'h1;
	assign flush_c = presp_bad || in_to || out_to || rstdev_hit;
	assign tx_cnt_nxt = tx_cnt_r + 6'(tx_pkt_sent) - 6'(pa_ok);

	//------------------------------------------------------------
	// Transmit symbol interface
	//------------------------------------------------------------
	// everything on one clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s0_out_valid_r <= 1'b0;
			s0_out_data_r <= '0;
			s1_out_valid_r <= 1'b0;
			s1_out_data_r <= '0;
			pkt_term_r <= 1'b0;
		end else if (ce) begin
			s0_out_valid_r <= s0_in_valid;
			s1_out_valid_r <= s1_in_valid;
			if (s0_in_valid) begin
				s0_out_data_r <= s0_in_data;
			end
			if (s1_in_valid) begin
				s1_out_data_r <= s1_in_data;
			end
			pkt_term_r <= s1_in_valid
				&& (s1_in_data[5:slfc_pkg::ST1_LSB] == slfc_pkg::ST1_STOMP
				|| s1_in_data[5:slfc_pkg::ST1_LSB] == slfc_pkg::ST1_RFR
				|| s1_in_data[5:slfc_pkg::ST1_LSB] == slfc_pkg::ST1_LREQ);
		end
	end

	//------------------------------------------------------------
	// Time base and send stamps
	//------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			now_r <= '0;
		end else if (ce) begin
			now_r <= now_r + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (ce && tx_pkt_sent) begin
			stamp[tx_ackid_r] <= now_r;
		end
	end

	//------------------------------------------------------------
	// Thresholds and free blocks
	//------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			thr2_r <= slfc_pkg::THR2_DEF;
			thr1_r <= slfc_pkg::THR1_DEF;
			thr0_r <= slfc_pkg::THR0_DEF;
		end else if (ce && cfg_thr_we) begin
			thr2_r <= cfg_thr2;
			thr1_r <= cfg_thr1;
			thr0_r <= cfg_thr0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			free_blks_r <= BLKS;
		end else if (ce) begin
			if (flush_c) begin
				free_blks_r <= BLKS;
			end else if (blk_alloc && !blk_free && free_blks_r != '0) begin
				free_blks_r <= free_blks_r - 10'h001;
			end else if (blk_free && !blk_alloc && free_blks_r != BLKS) begin
				free_blks_r <= free_blks_r + 10'h001;
			end
		end
	end

	//------------------------------------------------------------
	// Input port recovery and receive window
	//------------------------------------------------------------
	// input state machine
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_st_r <= slfc_pkg::in_ok;
			rx_exp_r <= '0;
			pkt_act_r <= 1'b0;
			pkt_blk_r <= '0;
			in_ts_r <= '0;
			ss_pa_r <= 1'b0;
			ss_retry_r <= 1'b0;
			ss_pna_r <= 1'b0;
			ss_lresp_r <= 1'b0;
			ss_ackid_r <= '0;
			rx_keep_r <= 1'b0;
			rx_drop_r <= 1'b0;
		end else if (ce) begin
			ss_pa_r <= 1'b0;
			ss_retry_r <= 1'b0;
			ss_pna_r <= 1'b0;
			ss_lresp_r <= 1'b0;
			rx_keep_r <= 1'b0;
			rx_drop_r <= 1'b0;
			if (blk_alloc && pkt_act_r) begin
				pkt_blk_r <= pkt_blk_r + 3'h1;
			end
			if (flush_c) begin
				in_st_r <= slfc_pkg::in_ok;
				pkt_act_r <= 1'b0;
			end else if (in_st_r == slfc_pkg::in_ok) begin
				if (err_in) begin
					ss_pna_r <= 1'b1;
					ss_ackid_r <= rx_exp_r;
					rx_drop_r <= pkt_act_r || rp_start;
					pkt_act_r <= 1'b0;
					in_st_r <= slfc_pkg::in_err;
					in_ts_r <= now_r;
				end else if (rp_end && pkt_act_r) begin
					ss_pa_r <= 1'b1;
					ss_ackid_r <= rx_exp_r;
					rx_keep_r <= 1'b1;
					rx_exp_r <= rx_exp_r + 5'h01;
					pkt_act_r <= 1'b0;
				end else if (rp_start && congest) begin
					ss_retry_r <= 1'b1;
					ss_ackid_r <= rp_ackid;
					rx_drop_r <= 1'b1;
				end else if (rp_start) begin
					pkt_act_r <= 1'b1;
					pkt_blk_r <= '0;
				end else if (rs_lreq && !rs_lreq_rstdev) begin
					ss_lresp_r <= 1'b1;
					ss_ackid_r <= rx_exp_r;
				end
			end else begin
				rx_drop_r <= rp_start;
				if (rs_lreq && !rs_lreq_rstdev) begin
					ss_lresp_r <= 1'b1;
					ss_ackid_r <= rx_exp_r;
					in_st_r <= slfc_pkg::in_ok;
				end
			end
		end
	end

	//------------------------------------------------------------
	// Output port recovery and transmit window
	//------------------------------------------------------------
	// output state machine
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_st_r <= slfc_pkg::out_ok;
			tx_ackid_r <= '0;
			tx_una_r <= '0;
			tx_cnt_r <= '0;
			tx_send_ok_r <= 1'b0;
			tx_free_r <= 1'b0;
			tx_free_ackid_r <= '0;
			tx_rewind_r <= 1'b0;
			ss_lreq_r <= 1'b0;
			out_ts_r <= '0;
		end else if (ce) begin
			tx_free_r <= 1'b0;
			tx_rewind_r <= 1'b0;
			ss_lreq_r <= 1'b0;
			// Sending pauses while either port recovers.
			tx_send_ok_r <= out_st_r == slfc_pkg::out_ok && in_st_r == slfc_pkg::in_ok
				&& !unexp && !flush_c && tx_cnt_nxt < slfc_pkg::MAX_OUT - 6'h01;
			if (flush_c) begin
				out_st_r <= slfc_pkg::out_ok;
				tx_una_r <= tx_ackid_r;
				tx_cnt_r <= '0;
			end else if (out_st_r == slfc_pkg::out_ok) begin
				if (unexp) begin
					out_st_r <= slfc_pkg::out_err;
					ss_lreq_r <= 1'b1;
					out_ts_r <= now_r;
				end else if (retry_ok) begin
					tx_ackid_r <= rs_ackid;
					tx_cnt_r <= '0;
					tx_rewind_r <= 1'b1;
				end else begin
					if (tx_pkt_sent) begin
						tx_ackid_r <= tx_ackid_r + 5'h01;
					end
					if (pa_ok) begin
						tx_free_r <= 1'b1;
						tx_free_ackid_r <= tx_una_r;
						tx_una_r <= tx_una_r + 5'h01;
					end
					tx_cnt_r <= tx_cnt_nxt;
				end
			end else if (rs_presp) begin
				tx_ackid_r <= rs_ackid;
				tx_una_r <= rs_ackid;
				tx_cnt_r <= '0;
				tx_rewind_r <= 1'b1;
				out_st_r <= slfc_pkg::out_ok;
			end
		end
	end

	//------------------------------------------------------------
	// Reset-device count and flush
	//------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rstdev_r <= '0;
			flush_r <= 1'b0;
		end else if (ce) begin
			flush_r <= flush_c;
			if (rs_lreq) begin
				rstdev_r <= (rs_lreq_rstdev && !rstdev_hit) ? rstdev_r + 3'h1 : 3'h0;
			end
		end
	end

	//------------------------------------------------------------
	// Receive data buffer
	//------------------------------------------------------------
	slfc_fifo_if #(.W(FIFO_W)) fq ();
	assign fq.in_valid = rx_data_valid;
	assign fq.in_data = rx_data;
	assign fq.out_ready = usr_ready;
	assign fq.clear = flush_c;
	assign rx_data_ready = fq.in_ready;
	assign usr_valid = fq.out_valid;
	assign usr_data = fq.out_data;

	slfc_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.f     (fq.fifo)
	);

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_rstdev4;
		rstdev_r == 3'h0 && ce && rs_lreq && rs_lreq_rstdev ##1
		(ce && rs_lreq && rs_lreq_rstdev)[*3];
	endsequence
	sequence s_good_start;
		ce && in_st_r == slfc_pkg::in_ok && !flush_c && !err_in && rp_start;
	endsequence

	property p_exp_step;
		$changed(rx_exp_r) |-> rx_exp_r == 5'($past(rx_exp_r) + 5'h01) && ss_pa_r;
	endproperty
	a_exp_step: assert property (p_exp_step) else $error("rx ackID jumped");
	property p_refuse;
		ce && !flush_c && rp_start && rp_ackid != rx_exp_r |=> rx_drop_r && !ss_pa_r;
	endproperty
	a_refuse: assert property (p_refuse) else $error("out of order packet taken");
	property p_retry_cause;
		ss_retry_r && $past(ce) |-> $past(rp_prio == 2'h3 ? free_blks_r == '0 : free_blks_r < thr_sel);
	endproperty
	a_retry_cause: assert property (p_retry_cause) else $error("retry without congestion");
	property p_p3_pass;
		s_good_start ##0 (rp_prio == 2'h3 && free_blks_r != '0) |=> !ss_retry_r && pkt_act_r;
	endproperty
	a_p3_pass: assert property (p_p3_pass) else $error("priority 3 refused");
	property p_rstdev;
		s_rstdev4 |-> flush_c ##1 flush_r;
	endproperty
	a_rstdev: assert property (p_rstdev) else $error("no flush on reset-device run");
	property p_free;
		tx_free_r && $past(ce) |-> $past(rs_pa && rs_ackid == tx_una_r && tx_cnt_r != '0);
	endproperty
	a_free: assert property (p_free) else $error("packet freed without accept");
	property p_timeout;
		ce && out_st_r == slfc_pkg::out_ok && !flush_c && pkt_to
		|=> out_st_r == slfc_pkg::out_err && ss_lreq_r;
	endproperty
	a_timeout: assert property (p_timeout) else $error("time-out ignored");
	property p_window;
		tx_cnt_r < slfc_pkg::MAX_OUT && tx_ackid_r == 5'(tx_una_r + tx_cnt_r[4:0]);
	endproperty
	a_window: assert property (p_window) else $error("tx window broken");
	property p_pna;
		ce && in_st_r == slfc_pkg::in_ok && !flush_c && rs_sym_err
		|=> ss_pna_r && in_st_r == slfc_pkg::in_err;
	endproperty
	a_pna: assert property (p_pna) else $error("symbol error not recovered");
	property p_blks;
		free_blks_r <= BLKS;
	endproperty
	a_blks: assert property (p_blks) else $error("free blocks above size");
endmodule

// ---- verif/slfc_partner.sv ----
// Purpose: Far-end model that acknowledges every packet the block sends.
// Assumes: Same clock as the block; packets are accepted strictly in order.
// Notes:   A fixed lag stands for the link flight time; en low keeps it silent.
`timescale 1ns/1ps
module slfc_partner #(
	parameter int unsigned LAG = 3
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       en,
	input  wire logic       sent,
	input  wire logic [4:0] ackid,
	output logic            pa,
	output logic [4:0]      pa_ackid
);
	logic [5:0] pipe_r [LAG];
	// ----------------------------------------------------------------
	// Acknowledge path
	// ----------------------------------------------------------------
	// In-order accepts.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < LAG; i++) begin
				pipe_r[i] <= 6'h00;
			end
		end else begin
			pipe_r[0] <= {sent & en, ackid};
			for (int i = 1; i < LAG; i++) begin
				pipe_r[i] <= pipe_r[i-1];
			end
		end
	end
	assign pa = pipe_r[LAG-1][5];
	// The ackID lines are not held between answers, so a stale value is never shown.
	assign pa_ackid = pa ? pipe_r[LAG-1][4:0] : ~pipe_r[LAG-1][4:0];
endmodule

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the serial link flow control block.
// Assumes: One 100 MHz clock; inputs change on the rising edge by NBA.
// Notes:   The time-out is shortened to 20 cycles to keep the run brief.
`timescale 1ns/1ps
module testbench;
	logic        clock = 1'b0, rst = 1'b1, s0_in_valid = 1'b0, s1_in_valid = 1'b0;
	logic        tx_pkt_sent = 1'b0, rs_lreq = 1'b0, rs_lreq_rstdev = 1'b0, rs_sym_err = 1'b0;
	logic        rp_start = 1'b0, rp_end = 1'b0, rp_crc_err = 1'b0, blk_alloc = 1'b0;
	logic        blk_free = 1'b0, cfg_thr_we = 1'b0, rx_data_valid = 1'b0, usr_ready = 1'b0;
	logic        p_en = 1'b0, ce = 1'b1;
	logic [12:0] s0_in_data = 13'h0000;
	logic [5:0]  s1_in_data = 6'h00;
	logic [4:0]  rp_ackid = 5'h00;
	logic [1:0]  rp_prio = 2'h0;
	logic [9:0]  cfg_thr2 = 10'h000, cfg_thr1 = 10'h000, cfg_thr0 = 10'h000;
	logic [31:0] rx_data = 32'h0000_0000;
	logic        s0_out_valid_r, s1_out_valid_r, pkt_term_r, tx_send_ok_r, tx_free_r;
	logic        tx_rewind_r, rs_pa, ss_pa_r, ss_retry_r, ss_pna_r, ss_lreq_r, ss_lresp_r;
	logic        rx_keep_r, rx_drop_r, flush_r, rx_data_ready, usr_valid;
	logic [12:0] s0_out_data_r;
	logic [5:0]  s1_out_data_r;
	logic [4:0]  tx_ackid_r, tx_free_ackid_r, rs_ackid, ss_ackid_r;
	logic [9:0]  free_blks_r;
	logic [31:0] usr_data;
	logic [8:0]  ev;
	int          n_errors = 0, check_count = 0;
	assign ev = {ss_pa_r, ss_retry_r, ss_pna_r, ss_lreq_r, ss_lresp_r, rx_keep_r, rx_drop_r,
		flush_r, tx_free_r};
	always #5 clock = ~clock;
	slfc_top #(.TO_CYC(16'h0014)) dut (.*, .rs_retry(1'b0), .rs_pna(1'b0),
		.rs_presp(1'b0), .rs_presp_err(1'b0));
	slfc_partner far (.clock(clock), .rst(rst), .en(p_en), .sent(tx_pkt_sent),
		.ackid(tx_ackid_r), .pa(rs_pa), .pa_ackid(rs_ackid));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits a bounded time for any masked event, then compares the masked set.
	task automatic wev(input logic [8:0] exp, input logic [8:0] mask, input int n);
		int i;
		i = 0;
		#1;
		while ((ev & mask) == 9'h000 && i < n) begin
			@(posedge clock);
			#1;
			i++;
		end
		chk(ev & mask, exp);
	endtask
	task automatic reset_dut;
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
	endtask
	task automatic rx_pkt(input logic [4:0] id, input logic [1:0] pr, input logic crc,
		input logic [8:0] e1, input logic [8:0] e2);
		@(posedge clock);
		rp_start <= 1'b1;
		rp_ackid <= id;
		rp_prio <= pr;
		@(posedge clock);
		rp_start <= 1'b0;
		wev(e1, 9'h1FF, 3);
		if (e2 !== 9'h000) begin
			@(posedge clock);
			rp_end <= 1'b1;
			rp_crc_err <= crc;
			@(posedge clock);
			rp_end <= 1'b0;
			wev(e2, 9'h1FF, 3);
		end
	endtask
	task automatic link_req(input logic rd, input logic [8:0] exp, input logic [8:0] mask);
		@(posedge clock);
		rs_lreq <= 1'b1;
		rs_lreq_rstdev <= rd;
		@(posedge clock);
		rs_lreq <= 1'b0;
		wev(exp, mask, 3);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_sym;
		for (int c = 0; c < 8; c++) begin
			@(posedge clock);
			s1_in_valid <= 1'b1;
			s1_in_data <= {c[2:0], 3'h5};
			s0_in_valid <= c[0];
			s0_in_data <= 13'h1A5C ^ c[12:0];
			@(posedge clock);
			s1_in_valid <= 1'b0;
			s0_in_valid <= 1'b0;
			#1;
			chk(pkt_term_r, c == 1 || c == 3 || c == 4);
			chk(s1_out_data_r, {c[2:0], 3'h5});
			chk(s0_out_valid_r, c[0]);
			chk(s1_out_valid_r, 1'b1);
			if (c[0]) begin
				chk(s0_out_data_r, 13'h1A5C ^ c[12:0]);
			end
		end
	endtask
	// Clock enable low must freeze the stype1 symbol path and the block count alike.
	task automatic t_ce;
		@(posedge clock);
		ce <= 1'b0;
		s1_in_valid <= 1'b1;
		s1_in_data <= 6'h08;
		blk_alloc <= 1'b1;
		@(posedge clock);
		ce <= 1'b1;
		s1_in_valid <= 1'b0;
		blk_alloc <= 1'b0;
		#1;
		chk(pkt_term_r, 1'b0);
		chk(s1_out_valid_r, 1'b0);
		chk(free_blks_r, 512);
	endtask
	task automatic t_rx;
		rx_pkt(5'h00, 2'h0, 1'b0, 9'h000, 9'h108);
		@(posedge clock);
		rs_sym_err <= 1'b1;
		@(posedge clock);
		rs_sym_err <= 1'b0;
		wev(9'h040, 9'h1FF, 3);
		link_req(1'b0, 9'h010, 9'h1FF);
		chk(ss_ackid_r, 5'h01);
		rx_pkt(5'h01, 2'h1, 1'b1, 9'h000, 9'h044);
		link_req(1'b0, 9'h010, 9'h1FF);
		rx_pkt(5'h03, 2'h0, 1'b0, 9'h044, 9'h000);
		link_req(1'b0, 9'h010, 9'h1FF);
		rx_pkt(5'h01, 2'h3, 1'b0, 9'h000, 9'h108);
		chk(ss_ackid_r, 5'h01);
		for (int i = 0; i < 4; i++) begin
			link_req(1'b1, {7'h00, i == 3, 1'b0}, 9'h002);
		end
		@(posedge clock);
		rs_lreq <= 1'b1;
		rs_lreq_rstdev <= 1'b1;
		repeat (4) @(posedge clock);
		rs_lreq <= 1'b0;
		wev(9'h002, 9'h002, 3);
	endtask
	task automatic t_tx;
		p_en <= 1'b1;
		for (int i = 0; i < 33; i++) begin
			for (int k = 0; k < 20 && tx_send_ok_r !== 1'b1; k++) begin
				@(posedge clock);
				#1;
			end
			chk(tx_send_ok_r, 1'b1);
			chk(tx_ackid_r, i % 32);
			@(posedge clock);
			tx_pkt_sent <= 1'b1;
			@(posedge clock);
			tx_pkt_sent <= 1'b0;
			wev(9'h001, 9'h001, 8);
			chk(tx_free_ackid_r, i % 32);
		end
		p_en <= 1'b0;
		@(posedge clock);
		tx_pkt_sent <= 1'b1;
		@(posedge clock);
		tx_pkt_sent <= 1'b0;
		wev(9'h020, 9'h020, 30);
		chk(tx_send_ok_r, 1'b0);
		wev(9'h002, 9'h002, 30);
	endtask
	task automatic t_thr(input int n, input logic [1:0] pr, input logic [9:0] t2,
		input logic [8:0] e);
		reset_dut;
		cfg_thr_we <= (t2 != 10'h000);
		cfg_thr2 <= t2;
		// Lower priorities sit exactly one largest packet (5 blocks) above.
		cfg_thr1 <= t2 + 10'h005;
		cfg_thr0 <= t2 + 10'h00A;
		@(posedge clock);
		cfg_thr_we <= 1'b0;
		blk_alloc <= 1'b1;
		repeat (n) @(posedge clock);
		blk_alloc <= 1'b0;
		blk_free <= 1'b1;
		@(posedge clock);
		blk_free <= 1'b0;
		blk_alloc <= 1'b1;
		@(posedge clock);
		blk_alloc <= 1'b0;
		#1;
		chk(free_blks_r, 512 - n);
		rx_pkt(5'h00, pr, 1'b0, e, 9'h000);
	endtask
	task automatic t_fifo;
		int n;
		n = 0;
		@(posedge clock);
		rx_data_valid <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			if (rx_data_ready === 1'b1) begin
				rx_data <= rx_data + 32'h0000_0001;
				n++;
			end
		end
		rx_data_valid <= 1'b0;
		chk(n, 32);
		chk(rx_data_ready, 1'b0);
		n = 0;
		for (int i = 0; i < 80; i++) begin
			@(posedge clock);
			if (usr_valid === 1'b1 && usr_ready === 1'b1) begin
				chk(usr_data, n);
				n++;
			end
			usr_ready <= i[0];
		end
		chk(n, 32);
		chk(usr_valid, 1'b0);
	endtask
	task automatic end_of_test;
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		reset_dut;
		t_sym;
		t_rx;
		reset_dut;
		t_tx;
		t_thr(493, 2'h0, 10'h000, 9'h084);
		t_thr(492, 2'h0, 10'h000, 9'h000);
		t_thr(498, 2'h1, 10'h000, 9'h084);
		t_thr(497, 2'h1, 10'h000, 9'h000);
		t_thr(503, 2'h2, 10'h000, 9'h084);
		t_thr(502, 2'h2, 10'h000, 9'h000);
		t_thr(512, 2'h3, 10'h000, 9'h084);
		t_thr(511, 2'h3, 10'h000, 9'h000);
		t_thr(501, 2'h2, 10'h00C, 9'h084);
		t_thr(500, 2'h2, 10'h00C, 9'h000);
		reset_dut;
		t_ce;
		t_fifo;
		end_of_test;
	end
	initial begin
		#200_000;
		n_errors++;
		end_of_test;
	end
endmodule
